// file: common/agc_pkg.sv
// constants and types shared by the amplifier control block
// Operation
// - three gain stages: preamp, two mixer volumes
// - preamp gain has four settings, 0 to 6 dB
// - preamp gain from analog config bits 1:0
// - converter volume from mixer register bits 5:0
// - serial volume from mixer register bits 13:8
// - 64 volume steps, -76.5 to 18 dB
// - all internal clocks from one reference clock
// - config bit 11 picks bit clock over master
// - rate field bits 10:8 matches reference frequency
// - five reference frequencies are accepted
// - bit 1 clear selects pin mode, default
// - pin level high runs, low disables device
// - edge option: each pin rising edge toggles
// - software mode: bit 0 enables the device
// - disabling keeps all register contents intact
// - bits 12 and 14 set halt oscillator
package agc_pkg;
   // ****************************************
   // register indices, byte address is index times four
   // ****************************************
   localparam logic [11:0] ECC_IDX = 12'h521;
   localparam logic [11:0] MIX_IDX = 12'h522;
   localparam logic [11:0] ANA_IDX = 12'h523;
   localparam logic [11:0] STAT_IDX = 12'h524;
   localparam int ADDR_W = 14;
   localparam logic [ADDR_W-1:0] ECC_ADDR = {ECC_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] MIX_ADDR = {MIX_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ANA_ADDR = {ANA_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
   // ****************************************
   // field positions
   // ****************************************
   localparam int ECC_EN_BIT = 0;
   localparam int ECC_FORCE_BIT = 1;
   localparam int ECC_PULSE_BIT = 2;
   localparam int ECC_RATE_LSB = 8;
   localparam int ECC_RATE_MSB = 10;
   localparam int ECC_CLKSEL_BIT = 11;
   localparam int ECC_OSCSEL_BIT = 12;
   localparam int ECC_OSCHALT_BIT = 14;
   localparam int MIX_CONV_LSB = 0;
   localparam int MIX_CONV_MSB = 5;
   localparam int MIX_SER_LSB = 8;
   localparam int MIX_SER_MSB = 13;
   localparam int ANA_GAIN_LSB = 0;
   localparam int ANA_GAIN_MSB = 1;
   // writable bits of each register, others read zero
   localparam logic [31:0] ECC_MASK = 32'h0000_5F07;
   localparam logic [31:0] MIX_MASK = 32'h0000_3F3F;
   localparam logic [31:0] ANA_MASK = 32'h0000_0003;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [31:0] ECC_RST = 32'h0000_0000;
   localparam logic [31:0] MIX_RST = 32'h0000_0000;
   localparam logic [31:0] ANA_RST = 32'h0000_0000;
   // ****************************************
   // encodings
   // ****************************************
   typedef enum logic [1:0] {
      GAIN_0DB = 2'h0,
      GAIN_2P4DB = 2'h1,
      GAIN_3P5DB = 2'h2,
      GAIN_6DB = 2'h3
   } agc_gain_t;
   typedef enum logic [2:0] {
      RATE_1P536 = 3'h0,
      RATE_3P072 = 3'h1,
      RATE_6P114 = 3'h2,
      RATE_12P288 = 3'h3,
      RATE_24P576 = 3'h4
   } agc_rate_t;
   // volume in tenths of dB: base plus step times code
   localparam logic signed [10:0] VOL_BASE_DB10 = -11'sd765;
   localparam logic signed [10:0] VOL_STEP_DB10 = 11'sd15;
   // preamp gain in tenths of dB per code
   localparam logic [5:0] GAIN_DB10_0 = 6'h00;
   localparam logic [5:0] GAIN_DB10_1 = 6'h18;
   localparam logic [5:0] GAIN_DB10_2 = 6'h23;
   localparam logic [5:0] GAIN_DB10_3 = 6'h3C;
   // shutdown control state
   typedef enum logic [2:0] {
      SD_RESET = 3'b001,
      SD_ON = 3'b010,
      SD_OFF = 3'b100
   } agc_sd_t;
endpackage

// file: common/agc_pin_if.sv
// carrier between top and shutdown pin detector
`timescale 1ns/1ns
`default_nettype none
interface agc_pin_if;
   logic level;
   logic rise;
   modport det (output level, output rise);
   modport use_side (input level, input rise);
endinterface
`default_nettype wire

// file: design/agc_pin_sync.sv
// shutdown pin synchroniser and rising edge detector
`timescale 1ns/1ns
`default_nettype none
module agc_pin_sync (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // pin and results
   input wire logic i_pin,
   agc_pin_if.det pin
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ****************************************
   // two flops, edge taken off the second only
   // ****************************************
   // pin idles high (run); resetting to that level avoids a false edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign pin.level = sync_q;
   assign pin.rise = sync_q & ~prev_q;
endmodule
`default_nettype wire

// file: design/agc_ctrl.sv
// register bank, gain decode, clock select and shutdown control
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module agc_ctrl
   import agc_pkg::*;
#(
   parameter int VOL_W = 6
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // shutdown pin
   input wire logic I_STANDBY_REQUEST_PIN,
   // gain settings
   output logic [1:0] O_PREAMP_GAIN_SEL,
   output logic [5:0] O_PREAMP_GAIN_DB10,
   output logic [VOL_W-1:0] O_CONVERTER_PATH_VOLUME,
   output logic [VOL_W-1:0] O_SERIAL_PATH_VOLUME,
   output logic signed [10:0] O_CONVERTER_VOL_DB10,
   output logic signed [10:0] O_SERIAL_VOL_DB10,
   // clocking
   output logic O_REF_CLK_SEL,
   output logic [2:0] O_REF_RATE,
   output logic O_RATE_RESERVED,
   output logic O_POWER_OSC_HALT,
   // device state
   output logic O_DEVICE_ENABLE
);
   // ****************************************
   // registers
   // ****************************************
   logic [31:0] ecc_q;
   logic [31:0] mix_q;
   logic [31:0] ana_q;
   logic run_q;
   agc_sd_t sd_q;
   agc_sd_t sd_d;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [31:0] rd_d;
   logic [31:0] wmask;
   logic rate_bad;
   logic [VOL_W-1:0] conv_code;
   logic [VOL_W-1:0] ser_code;
   logic [1:0] gain_code;
   logic [5:0] gain_db10;

   agc_pin_if pin ();

   agc_pin_sync u_pin (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_pin(I_STANDBY_REQUEST_PIN),
      .pin(pin)
   );

   // ****************************************
   // apb decode, zero wait state
   // ****************************************
   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign hit = (I_PADDR == ECC_ADDR) || (I_PADDR == MIX_ADDR)
      || (I_PADDR == ANA_ADDR) || (I_PADDR == STAT_ADDR);

   generate
      for (genvar b = 0; b < 4; b++) begin : g_strb
         assign wmask[8*b +: 8] = {8{I_PSTRB[b]}};
      end
   endgenerate

   // registers hold through any shutdown; only reset clears them
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         ecc_q <= ECC_RST;
         mix_q <= MIX_RST;
         ana_q <= ANA_RST;
      end else if (wr_en) begin
         if (I_PADDR == ECC_ADDR) begin
            ecc_q <= ((ecc_q & ~wmask) | (I_PWDATA & wmask)) & ECC_MASK;
         end
         if (I_PADDR == MIX_ADDR) begin
            mix_q <= ((mix_q & ~wmask) | (I_PWDATA & wmask)) & MIX_MASK;
         end
         if (I_PADDR == ANA_ADDR) begin
            ana_q <= ((ana_q & ~wmask) | (I_PWDATA & wmask)) & ANA_MASK;
         end
      end
   end

   // status: bit 0 device enabled, bit 1 rate reserved
   always_comb begin
      rd_d = 32'h0000_0000;
      case (I_PADDR)
         ECC_ADDR: rd_d = ecc_q;
         MIX_ADDR: rd_d = mix_q;
         ANA_ADDR: rd_d = ana_q;
         STAT_ADDR: rd_d = {30'h0, rate_bad, run_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0000_0000;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= I_PSEL & ~I_PENABLE & ~hit;
         if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
            O_PRDATA <= hit ? rd_d : 32'h0000_0000;
         end
      end
   end

   // ****************************************
   // gain and volume decode
   // ****************************************
   assign gain_code = ana_q[ANA_GAIN_MSB:ANA_GAIN_LSB];
   assign conv_code = mix_q[MIX_CONV_MSB:MIX_CONV_LSB];
   assign ser_code = mix_q[MIX_SER_MSB:MIX_SER_LSB];

   always_comb begin
      case (agc_gain_t'(gain_code))
         GAIN_0DB: gain_db10 = GAIN_DB10_0;
         GAIN_2P4DB: gain_db10 = GAIN_DB10_1;
         GAIN_3P5DB: gain_db10 = GAIN_DB10_2;
         GAIN_6DB: gain_db10 = GAIN_DB10_3;
         default: gain_db10 = GAIN_DB10_0;
      endcase
   end

   function automatic logic signed [10:0] vol_db10(
      input logic [VOL_W-1:0] code
   );
      logic signed [10:0] c;
      c = signed'(11'(code));
      return 11'(VOL_BASE_DB10 + c * VOL_STEP_DB10);
   endfunction

   // three independent stages latched to outputs
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_PREAMP_GAIN_SEL <= 2'h0;
         O_PREAMP_GAIN_DB10 <= GAIN_DB10_0;
         O_CONVERTER_PATH_VOLUME <= '0;
         O_SERIAL_PATH_VOLUME <= '0;
         O_CONVERTER_VOL_DB10 <= VOL_BASE_DB10;
         O_SERIAL_VOL_DB10 <= VOL_BASE_DB10;
      end else begin
         O_PREAMP_GAIN_SEL <= gain_code;
         O_PREAMP_GAIN_DB10 <= gain_db10;
         O_CONVERTER_PATH_VOLUME <= conv_code;
         O_SERIAL_PATH_VOLUME <= ser_code;
         O_CONVERTER_VOL_DB10 <= vol_db10(conv_code);
         O_SERIAL_VOL_DB10 <= vol_db10(ser_code);
      end
   end

   // ****************************************
   // reference clock selection and rate
   // ****************************************
   always_comb begin
      case (ecc_q[ECC_RATE_MSB:ECC_RATE_LSB])
         RATE_1P536, RATE_3P072, RATE_6P114,
         RATE_12P288, RATE_24P576: rate_bad = 1'b0;
         default: rate_bad = 1'b1;
      endcase
   end

   // one selected reference feeds every internal clock domain
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_REF_CLK_SEL <= 1'b0;
         O_REF_RATE <= 3'h0;
         O_RATE_RESERVED <= 1'b0;
         O_POWER_OSC_HALT <= 1'b0;
      end else begin
         O_REF_CLK_SEL <= ecc_q[ECC_CLKSEL_BIT];
         O_REF_RATE <= ecc_q[ECC_RATE_MSB:ECC_RATE_LSB];
         O_RATE_RESERVED <= rate_bad;
         O_POWER_OSC_HALT <= ecc_q[ECC_OSCSEL_BIT]
            & ecc_q[ECC_OSCHALT_BIT];
      end
   end

   // ****************************************
   // shutdown control
   // ****************************************
   // edge mode starts from the state the previous mode left; level mode follows the pin directly
   always_comb begin
      sd_d = sd_q;
      if (ecc_q[ECC_FORCE_BIT]) begin
         sd_d = ecc_q[ECC_EN_BIT] ? SD_ON : SD_OFF;
      end else if (ecc_q[ECC_PULSE_BIT]) begin
         case (sd_q)
            SD_RESET: sd_d = SD_ON;
            SD_ON: sd_d = pin.rise ? SD_OFF : SD_ON;
            SD_OFF: sd_d = pin.rise ? SD_ON : SD_OFF;
            default: sd_d = SD_ON;
         endcase
      end else begin
         sd_d = pin.level ? SD_ON : SD_OFF;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         sd_q <= SD_RESET;
      end else begin
         sd_q <= sd_d;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         run_q <= 1'b0;
         O_DEVICE_ENABLE <= 1'b0;
      end else begin
         run_q <= (sd_d == SD_ON);
         O_DEVICE_ENABLE <= (sd_d == SD_ON);
      end
   end
endmodule
`default_nettype wire

// file: tb/agc_ctrl_checker.sv
// port assertions for the amplifier control block
`timescale 1ns/1ns
`default_nettype none
module agc_ctrl_checker
   import agc_pkg::*;
#(
   parameter int VOL_W = 6
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // apb
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   // settings
   input wire logic [1:0] O_PREAMP_GAIN_SEL,
   input wire logic [5:0] O_PREAMP_GAIN_DB10,
   input wire logic [VOL_W-1:0] O_CONVERTER_PATH_VOLUME,
   input wire logic [VOL_W-1:0] O_SERIAL_PATH_VOLUME,
   input wire logic signed [10:0] O_CONVERTER_VOL_DB10,
   input wire logic O_REF_CLK_SEL,
   input wire logic [2:0] O_REF_RATE,
   input wire logic O_POWER_OSC_HALT,
   input wire logic O_DEVICE_ENABLE
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   // ****************
   // full-word write
   // ****************
   // partial strobes left to the bench, output lags register by one
   logic wr;
   assign wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & (I_PSTRB == 4'hF);
   gain_field_a: assert property (
      wr && I_PADDR == ANA_ADDR |-> ##2
      O_PREAMP_GAIN_SEL == $past(I_PWDATA[1:0], 2))
      else $error("preamp gain field not applied");
   conv_vol_a: assert property (
      wr && I_PADDR == MIX_ADDR |-> ##2
      O_CONVERTER_PATH_VOLUME == $past(I_PWDATA[5:0], 2))
      else $error("converter volume not applied");
   ser_vol_a: assert property (
      wr && I_PADDR == MIX_ADDR |-> ##2
      O_SERIAL_PATH_VOLUME == $past(I_PWDATA[13:8], 2))
      else $error("serial volume not applied");
   vol_db_a: assert property (int'(O_CONVERTER_VOL_DB10) ==
      int'(VOL_BASE_DB10) + int'(VOL_STEP_DB10)
      * int'(O_CONVERTER_PATH_VOLUME))
      else $error("volume step map wrong");
   gain_db_a: assert property (O_PREAMP_GAIN_DB10 == (
      O_PREAMP_GAIN_SEL[1] ? (O_PREAMP_GAIN_SEL[0] ? 6'h3C : 6'h23)
      : (O_PREAMP_GAIN_SEL[0] ? 6'h18 : 6'h00)))
      else $error("preamp gain value wrong");
   clk_field_a: assert property (
      wr && I_PADDR == ECC_ADDR |-> ##2
      {O_REF_CLK_SEL, O_REF_RATE} == $past(I_PWDATA[11:8], 2))
      else $error("clock select or rate not applied");
   osc_halt_a: assert property (
      wr && I_PADDR == ECC_ADDR |-> ##2
      O_POWER_OSC_HALT == $past(I_PWDATA[12] & I_PWDATA[14], 2))
      else $error("oscillator halt wrong");
   sw_enable_a: assert property (
      wr && I_PADDR == ECC_ADDR && I_PWDATA[1] |-> ##2
      O_DEVICE_ENABLE == $past(I_PWDATA[0], 2))
      else $error("software enable not followed");
   cover property (wr && I_PADDR == ECC_ADDR && I_PWDATA[1]);
   cover property ($fell(O_DEVICE_ENABLE));
   cover property (O_PSLVERR);
endmodule
`default_nettype wire

// file: tb/agc_pin_model.sv
// board-side driver of the shutdown pin
`timescale 1ns/1ns
`default_nettype none
module agc_pin_model (
   // clock
   input wire logic i_clk,
   // pin
   output logic o_pin
);
   initial o_pin = 1'h1;
   // level held three clocks so the synchroniser always sees it
   task automatic drive(input logic v);
      @(posedge i_clk);
      o_pin <= v;
      repeat (3) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the amplifier control block
`timescale 1ns/1ns
`default_nettype none
module testbench
   import agc_pkg::*;
;
   localparam logic WR = 1'h1, RD = 1'h0, OK = 1'h0, ERR = 1'h1;
   logic clk = 1'h0;
   logic rst, psel, pen, pwr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr, pin, en, sel, resv, halt;
   logic [1:0] gsel;
   logic [5:0] gdb, cv, sv;
   logic signed [10:0] cdb, sdb;
   logic [2:0] rate;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   always #25 clk = ~clk;
   agc_pin_model pin_m (.i_clk(clk), .o_pin(pin));
   agc_ctrl dut (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_STANDBY_REQUEST_PIN(pin),
      .O_PREAMP_GAIN_SEL(gsel), .O_PREAMP_GAIN_DB10(gdb),
      .O_CONVERTER_PATH_VOLUME(cv), .O_SERIAL_PATH_VOLUME(sv),
      .O_CONVERTER_VOL_DB10(cdb), .O_SERIAL_VOL_DB10(sdb),
      .O_REF_CLK_SEL(sel), .O_REF_RATE(rate), .O_RATE_RESERVED(resv),
      .O_POWER_OSC_HALT(halt), .O_DEVICE_ENABLE(en));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(negedge clk);
   endtask
   // ****************
   // apb transfer
   // ****************
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, input logic ee, input logic [31:0] ed);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 20), 32'h1);
      if (!w) chk(prdata, ed);
      chk(32'(pslverr), 32'(ee));
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic t_gain;
      logic [5:0] db [4] = '{6'h00, 6'h18, 6'h23, 6'h3C};
      apb(RD, ECC_ADDR, 0, OK, ECC_RST);
      apb(RD, MIX_ADDR, 0, OK, MIX_RST);
      chk(en, 32'h1);
      for (int g = 0; g < 4; g++) begin
         apb(WR, ANA_ADDR, 32'hFFFF_FFFC | g, OK, 0);
         wt(2);
         chk(gsel, g);
         chk(gdb, db[g]);
         apb(RD, ANA_ADDR, 0, OK, g);
      end
      $display("gain test done");
   endtask
   task automatic t_vol;
      apb(WR, MIX_ADDR, 32'hFFFF_FF00, OK, 0);
      wt(2);
      chk(cv, 0);
      chk(sv, 32'h3F);
      chk(cdb, 32'hFFFF_FD03);
      chk(sdb, 32'h0000_00B4);
      @(posedge clk);
      pstrb <= 4'h1;
      apb(WR, MIX_ADDR, 32'h0000_0020, OK, 0);
      pstrb <= 4'hF;
      wt(2);
      chk(cdb, 32'hFFFF_FEE3);
      apb(RD, MIX_ADDR, 0, OK, 32'h0000_3F20);
      $display("volume test done");
   endtask
   task automatic t_clk;
      for (int r = 0; r < 8; r++) begin
         apb(WR, ECC_ADDR, (r << 8) | ((r & 1) << 11), OK, 0);
         wt(2);
         chk(rate, r);
         chk(resv, r > 4);
         chk(sel, r & 1);
      end
      apb(WR, ECC_ADDR, 32'h0000_0000, OK, 0);
      wt(2);
      chk({sel, rate}, 32'h0);
      $display("clock test done");
   endtask
   task automatic t_pin;
      pin_m.drive(1'h0);
      wt(2);
      chk(en, 0);
      pin_m.drive(1'h1);
      wt(2);
      chk(en, 1);
      apb(WR, ECC_ADDR, 32'h0000_0004, OK, 0);
      pin_m.drive(1'h0);
      wt(2);
      chk(en, 1);
      pin_m.drive(1'h1);
      wt(2);
      chk(en, 0);
      pin_m.drive(1'h0);
      pin_m.drive(1'h1);
      wt(2);
      chk(en, 1);
      $display("pin test done");
   endtask
   task automatic t_sw;
      apb(WR, ECC_ADDR, 32'hFFFF_FFFE, OK, 0);
      wt(2);
      chk(en, 0);
      apb(RD, ECC_ADDR, 0, OK, 32'h0000_5F06);
      apb(WR, ECC_ADDR, 32'h0000_5003, OK, 0);
      wt(2);
      chk({en, halt}, 32'h3);
      apb(RD, STAT_ADDR, 0, OK, 32'h1);
      apb(WR, ECC_ADDR, 32'h0000_4002, OK, 0);
      wt(2);
      chk({en, halt}, 32'h0);
      apb(RD, MIX_ADDR, 0, OK, 32'h0000_3F20);
      apb(RD, STAT_ADDR + 4, 0, ERR, 0);
      apb(WR, 14'h0000, 32'hFFFF_FFFF, ERR, 0);
      apb(RD, ANA_ADDR, 0, OK, 32'h3);
      $display("software test done");
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim;
      end
   end
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      pen = 1'h0;
      pwr = 1'h0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      t_gain;
      t_vol;
      t_clk;
      t_pin;
      t_sw;
      end_sim;
   end
endmodule
bind agc_ctrl agc_ctrl_checker #(.VOL_W(VOL_W)) u_chk (.I_REF_CLK, .I_RST,
   .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PREADY,
   .O_PSLVERR, .O_PREAMP_GAIN_SEL, .O_PREAMP_GAIN_DB10,
   .O_CONVERTER_PATH_VOLUME, .O_SERIAL_PATH_VOLUME, .O_CONVERTER_VOL_DB10,
   .O_REF_CLK_SEL, .O_REF_RATE, .O_POWER_OSC_HALT, .O_DEVICE_ENABLE);
`default_nettype wire
